// ===== vlan_tag_class_and_lag_code_tb.sv
// self-checking bench for the vlan tag classifier and lag code block
`timescale 1ns/10ps
`default_nettype none
module vlan_tag_class_and_lag_code_tb;
   typedef struct packed {
      logic [1:0]       cnt;
      logic [2:0][15:0] et;
      logic [2:0][15:0] tci;
      logic [47:0]      dmac;
      logic [47:0]      smac;
      logic             ip;
      logic             ip6;
      logic [19:0]      flow;
      logic [127:0]     sip;
      logic [127:0]     dip;
      logic             l4;
      logic [15:0]      sp;
      logic [15:0]      dp;
      logic             stk;
      logic [3:0]       code;
   } vtlc_frm_t;
   logic                mclk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, ctl, rdat;
   logic                go, frm_vld, res_vld, dei, ttype, wtag, rerr;
   vtlc_frm_t           f, fo;
   logic [2:0]          pcp;
   logic [11:0]         vid;
   vtlc_pkg::vtlc_ext_t ext;
   logic [1:0]          pop;
   logic [3:0]          lag;
   logic [15:0]         cpu_en[3];
   logic [4:0]          inv;
   logic [7:0]          lc;
   logic [15:0]         cst[3];
   logic [3:0]          xl[16];
   logic [26:0]         lastex;
   logic                ce;
   logic [3:0]          lf, lf_q;
   int                  bad_count, samples_checked, n;

   vtlc_parser_model partner (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .go_i      (go),
      .frame_i   (f),
      .frm_vld_o (frm_vld),
      .frame_o   (fo)
   );

   vtlc_core dut (
      .mclk_i                     (mclk_i),
      .rst_n_i                    (rst_n_i),
      .ce_i                       (ce),
      .psel_i                     (psel),
      .penable_i                  (penable),
      .pwrite_i                   (pwrite),
      .paddr_i                    (paddr),
      .pwdata_i                   (pwdata),
      .prdata_o                   (prdata),
      .pready_o                   (pready),
      .pslverr_o                  (pslverr),
      .frm_vld_i                  (frm_vld),
      .tag_cnt_i                  (fo.cnt),
      .etype_i                    (fo.et),
      .tci_i                      (fo.tci),
      .dmac_i                     (fo.dmac),
      .smac_i                     (fo.smac),
      .is_ip_i                    (fo.ip),
      .is_ip6_i                   (fo.ip6),
      .flow_lbl_i                 (fo.flow),
      .sip_i                      (fo.sip),
      .dip_i                      (fo.dip),
      .is_l4_i                    (fo.l4),
      .sport_i                    (fo.sp),
      .dport_i                    (fo.dp),
      .stk_vld_i                  (fo.stk),
      .stk_code_i                 (fo.code),
      .res_vld_o                  (res_vld),
      .classified_priority_o      (pcp),
      .classified_drop_eligible_o (dei),
      .classified_vlan_id_o       (vid),
      .tag_type_o                 (ttype),
      .extended_tpid_info_o       (ext),
      .egress_tag_strip_count_o   (pop),
      .was_tagged_o               (wtag),
      .lag_code_o                 (lag),
      .bridge_proto_cpu_enables_o (cpu_en[0]),
      .garp_cpu_enables_o         (cpu_en[1]),
      .cfm_cpu_enables_o          (cpu_en[2])
   );

   always #5 mclk_i = ~mclk_i;

   // random source mirror, x^4+x^3+1 stepping on every enabled edge
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lf   <= 4'h1;
         lf_q <= 4'h1;
      end else if (ce) begin
         lf_q <= lf;
         lf   <= {lf[2:0], lf[3] ^ lf[2]};
      end
   end

   function automatic logic [3:0] fold(input logic [127:0] v);
      fold = 4'h0;
      for (int i = 0; i < 32; i++) fold ^= v[i*4 +: 4];
   endfunction

   // reference: {lag, was tagged, strip count, ext, type, vid, dei, pcp}
   function automatic logic [26:0] expect_res(input vtlc_frm_t fr);
      int          nv;
      int          s;
      int          kd[3];
      bit          stop;
      logic [15:0] c;
      logic [3:0]  x;
      logic [3:0]  lg;
      logic [47:0] r;
      logic [1:0]  pp;
      logic [19:0] cls;
      nv = 0;
      stop = 0;
      kd = '{0, 0, 0};
      for (int k = 0; k < 3; k++) begin
         if (k < int'(fr.cnt) && !stop) begin
            kd[k] = (fr.et[k] == 16'h8100) ? 0 : (fr.et[k] == 16'h88A8) ? 1 :
                    (fr.et[k] == cst[0]) ? 2 : (fr.et[k] == cst[1]) ? 3 :
                    (fr.et[k] == cst[2]) ? 4 : 5;
            if (kd[k] == 5 || inv[kd[k]]) stop = 1;
            else nv++;
         end
      end
      s = (nv >= 2 && ctl[16]) ? 1 : 0;
      c = fr.tci[s];
      x = xl[{c[12], c[15:13]}];
      cls = {3'(kd[s] + 1), kd[s] != 0, c[11:0], x[3], x[2:0]};
      if (nv == 0) cls = {4'h0, ctl[11:0], ctl[15], ctl[14:12]};
      pp = (int'(ctl[18:17]) > nv) ? 2'(nv) : ctl[18:17];
      for (int k = 0; k < 48; k++) r[k] = fr.dmac[47 - k];
      lg = 4'h0;
      if (lc[0]) lg ^= fold(128'(fr.dmac));
      if (lc[1]) lg ^= fold(128'(r));
      if (lc[2]) lg ^= fold(128'(fr.smac));
      if (lc[3] && fr.ip6) lg ^= fold(128'(fr.flow));
      if (lc[4] && fr.ip) lg ^= fold(fr.sip ^ fr.dip);
      if (lc[5] && fr.l4) lg ^= fold(128'({fr.sp, fr.dp}));
      if (lc[7] && fr.stk) lg = fr.code;
      return {lg, ctl[19] && nv > 0, pp, cls};
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_frm(input logic [26:0] g, input logic [26:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      @(posedge mclk_i);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge mclk_i);
         w++;
      end while (pready !== 1'b1 && w < 20);
      if (w == 20) bad_count++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk_reg(rdat, e);
      chk_reg({31'h0, rerr}, {31'h0, ee});
   endtask

   task automatic cfg();
      ctl = 32'($urandom) & 32'h000FFFFF;
      inv = ($urandom % 2 == 0) ? 5'h00 : 5'($urandom);
      lc  = 8'($urandom);
      wr(8'h00, ctl);
      wr(8'h04, {27'h0, inv});
      wr(8'h14, {24'h0, lc});
      for (int k = 0; k < 16; k++) begin
         xl[k] = 4'($urandom);
         wr(8'(8'h40 + 4 * k), {28'h0, xl[k]});
      end
   endtask

   task automatic frame();
      vtlc_frm_t   nf;
      logic [15:0] pk[6];
      logic [26:0] ex;
      logic [26:0] got;
      int          w;
      pk = '{16'h8100, 16'h88A8, cst[0], cst[1], cst[2], 16'h0800};
      for (int k = 0; k < 15; k++) nf[k*32 +: 32] = $urandom;
      nf[509:480] = 30'($urandom);
      for (int k = 0; k < 3; k++) begin
         nf.et[k] = pk[$urandom % 6];
         if ($urandom % 3 == 0) nf.tci[k][11:0] = 12'h000;
      end
      if (!nf.ip6) nf.sip[127:32] = '0;
      if (!nf.ip6) nf.dip[127:32] = '0;
      ex = expect_res(nf);
      @(posedge mclk_i);
      f  <= nf;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      w = 0;
      do begin
         @(posedge mclk_i);
         w++;
      end while (res_vld !== 1'b1 && w < 20);
      if (lc[6] && !(lc[7] && nf.stk)) ex[26:23] = ex[26:23] ^ lf_q;
      got = {lag, wtag, pop, ext, ttype, vid, dei, pcp};
      chk_frm(27'(got[19:16]), 27'(ex[19:16]));
      chk_frm(27'(got[15:4]), 27'(ex[15:4]));
      chk_frm(27'(got[3:0]), 27'(ex[3:0]));
      chk_frm(27'(got[22:20]), 27'(ex[22:20]));
      chk_frm(27'(got[26:23]), 27'(ex[26:23]));
      lastex = ex;
   endtask

   initial begin
      mclk_i = 1'b0;
      rst_n_i = 1'b0;
      {psel, penable, pwrite, go, paddr, pwdata} = '0;
      ce = 1'b1;
      f = '0;
      bad_count = 0;
      samples_checked = 0;
      rdat = $urandom(22559);
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int k = 0; k < 3; k++) rchk(8'(8'h08 + 4 * k), 32'h0000FFFF, 1'b0);
      rchk(8'h04, 32'h0, 1'b0);
      for (int k = 0; k < 16; k++) rchk(8'(8'h40 + 4 * k), 32'(k), 1'b0);
      rchk(8'h30, 32'h0, 1'b1);
      rchk(8'h02, 32'h0, 1'b1);
      wr(8'h00, 32'hFFFFFFFF);
      rchk(8'h00, 32'h000FFFFF, 1'b0);
      for (int k = 0; k < 3; k++) begin
         ctl = 32'($urandom) & 32'h0000FFFF;
         wr(8'(8'h18 + 4 * k), ctl);
         rchk(8'(8'h18 + 4 * k), ctl, 1'b0);
         chk_reg({16'h0, cpu_en[k]}, ctl);
      end
      for (int k = 0; k < 3; k++) begin
         cst[k] = 16'(16'h9100 + 16'h0100 * k + $urandom % 256);
         wr(8'(8'h08 + 4 * k), {16'h0, cst[k]});
      end
      for (n = 0; n < 400; n++) begin
         if (n % 25 == 0) cfg();
         frame();
      end
      // frozen core ignores a strobe and holds its results
      @(posedge mclk_i);
      ce <= 1'b0;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk_reg({31'h0, res_vld}, 32'h0);
      chk_frm({lag, wtag, pop, ext, ttype, vid, dei, pcp}, lastex);
      ce <= 1'b1;
      wr(8'h24, 32'hFFFFFFFF);
      rchk(8'h24, {10'h0, lastex[21:20], lastex[26:23], 16'h0190}, 1'b0);
      end_of_test();
   end

   initial begin
      #500000;
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== vtlc_core.sv
// vlan tag classifier and link aggregation code generator with apb registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "vtlc_params.svh"
module vtlc_core (
   input  wire logic                  mclk_i,        // core clock
   input  wire logic                  rst_n_i,       // async reset
   input  wire logic                  ce_i,          // clock enable
   input  wire logic                  psel_i,        // apb select
   input  wire logic                  penable_i,     // apb enable
   input  wire logic                  pwrite_i,      // apb write
   input  wire logic [7:0]            paddr_i,       // apb byte address
   input  wire logic [31:0]           pwdata_i,      // apb write data
   output logic      [31:0]           prdata_o,      // apb read data
   output logic                       pready_o,      // apb ready
   output logic                       pslverr_o,     // apb error
   input  wire logic                  frm_vld_i,     // frame header strobe
   input  wire logic [1:0]            tag_cnt_i,     // tags seen by parser
   input  wire logic [2:0][15:0]      etype_i,       // ethertype before tag k
   input  wire logic [2:0][15:0]      tci_i,         // tag control of tag k
   input  wire logic [47:0]           dmac_i,        // destination mac
   input  wire logic [47:0]           smac_i,        // source mac
   input  wire logic                  is_ip_i,       // ipv4 or ipv6 frame
   input  wire logic                  is_ip6_i,      // ipv6 frame
   input  wire logic [19:0]           flow_lbl_i,    // ipv6 flow label
   input  wire logic [127:0]          sip_i,         // source ip
   input  wire logic [127:0]          dip_i,         // destination ip
   input  wire logic                  is_l4_i,       // tcp or udp present
   input  wire logic [15:0]           sport_i,       // l4 source port
   input  wire logic [15:0]           dport_i,       // l4 destination port
   input  wire logic                  stk_vld_i,     // stacking header seen
   input  wire logic [3:0]            stk_code_i,    // its aggregation code
   output logic                       res_vld_o,     // result strobe
   output logic      [2:0]            classified_priority_o,      // pcp
   output logic                       classified_drop_eligible_o, // dei
   output logic      [11:0]           classified_vlan_id_o,       // vid
   output logic                       tag_type_o,                 // 1 service
   output vtlc_pkg::vtlc_ext_t        extended_tpid_info_o,       // tag kind
   output logic      [1:0]            egress_tag_strip_count_o,   // pop
   output logic                       was_tagged_o,               // tagged
   output logic      [3:0]            lag_code_o,                 // lag code
   output logic      [15:0]           bridge_proto_cpu_enables_o, // bpdu
   output logic      [15:0]           garp_cpu_enables_o,         // garp
   output logic      [15:0]           cfm_cpu_enables_o           // cfm
);
   import vtlc_pkg::*;

   vtlc_state_t st_reg;
   vtlc_state_t st_next;
   vtlc_ext_t   kd [3];
   logic [1:0]  nv;
   logic        run;
   logic [1:0]  sel;
   logic [1:0]  cfg_pop;
   logic [3:0]  acc;
   logic [3:0]  pd;
   logic        hit;
   logic [31:0] rd;
   logic        acc_ph;

   function automatic vtlc_state_t rst_state();
      vtlc_state_t s;
      s = '0;
      s.ctl  = `VTLC_RST_CTL;
      s.cst  = {3{`VTLC_RST_CST}};
      s.lfsr = `VTLC_RST_LFSR;
      for (int i = 0; i < 16; i++) begin
         s.xlat[i] = 4'(i);
      end
      return s;
   endfunction

   localparam vtlc_state_t ST_RST = rst_state();

   function automatic vtlc_ext_t tpid_kind(input logic [15:0]      et,
                                           input logic [2:0][15:0] cs);
      vtlc_ext_t t;
      t = VTLC_EXT_NONE;
      if (et == `VTLC_TPID_C) begin
         t = VTLC_EXT_C;
      end else if (et == `VTLC_TPID_S) begin
         t = VTLC_EXT_S;
      end else if (et == cs[0]) begin
         t = VTLC_EXT_X0;
      end else if (et == cs[1]) begin
         t = VTLC_EXT_X1;
      end else if (et == cs[2]) begin
         t = VTLC_EXT_X2;
      end
      return t;
   endfunction

   // xor of all nibbles
   function automatic logic [3:0] fold(input logic [127:0] v);
      logic [3:0] f;
      f = 4'h0;
      for (int i = 0; i < 32; i++) begin
         f = f ^ v[4*i +: 4];
      end
      return f;
   endfunction

   function automatic logic [47:0] mirror48(input logic [47:0] v);
      logic [47:0] m;
      m = '0;
      for (int i = 0; i < 48; i++) begin
         m[i] = v[47-i];
      end
      return m;
   endfunction

   assign acc_ph = psel_i && penable_i;

   // register read decode
   always_comb begin
      hit = 1'b1;
      rd  = 32'h0000_0000;
      if (paddr_i[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (paddr_i[7:6] == `VTLC_XLAT_SEL) begin
         rd[3:0] = st_reg.xlat[paddr_i[5:2]];
      end else begin
         unique case (paddr_i)
            `VTLC_OFS_CTL:  rd[19:0] = st_reg.ctl;
            `VTLC_OFS_INV:  rd[4:0]  = st_reg.inv;
            `VTLC_OFS_CST0: rd[15:0] = st_reg.cst[0];
            `VTLC_OFS_CST1: rd[15:0] = st_reg.cst[1];
            `VTLC_OFS_CST2: rd[15:0] = st_reg.cst[2];
            `VTLC_OFS_LAG:  rd[7:0]  = st_reg.lag_cfg;
            `VTLC_OFS_BPDU: rd[15:0] = st_reg.bpdu;
            `VTLC_OFS_GARP: rd[15:0] = st_reg.garp;
            `VTLC_OFS_CFM:  rd[15:0] = st_reg.cfm;
            `VTLC_OFS_STAT: rd[21:0] = {st_reg.pop, st_reg.lag, st_reg.fcnt};
            default:        hit = 1'b0;
         endcase
      end
   end

   always_comb begin
      st_next = st_reg;
      // apb: one wait state, write lands on the completing edge
      st_next.rdy = 1'b0;
      st_next.err = 1'b0;
      if (acc_ph && !st_reg.rdy) begin
         st_next.rdy   = 1'b1;
         st_next.err   = !hit;
         st_next.rdata = pwrite_i ? 32'h0000_0000 : rd;
      end
      if (acc_ph && st_reg.rdy && pwrite_i && hit) begin
         if (paddr_i[7:6] == `VTLC_XLAT_SEL) begin
            st_next.xlat[paddr_i[5:2]] = pwdata_i[3:0];
         end else begin
            unique case (paddr_i)
               `VTLC_OFS_CTL:  st_next.ctl     = pwdata_i[19:0];
               `VTLC_OFS_INV:  st_next.inv     = pwdata_i[4:0];
               `VTLC_OFS_CST0: st_next.cst[0]  = pwdata_i[15:0];
               `VTLC_OFS_CST1: st_next.cst[1]  = pwdata_i[15:0];
               `VTLC_OFS_CST2: st_next.cst[2]  = pwdata_i[15:0];
               `VTLC_OFS_LAG:  st_next.lag_cfg = pwdata_i[7:0];
               `VTLC_OFS_BPDU: st_next.bpdu    = pwdata_i[15:0];
               `VTLC_OFS_GARP: st_next.garp    = pwdata_i[15:0];
               `VTLC_OFS_CFM:  st_next.cfm     = pwdata_i[15:0];
               default:        st_next.fcnt    = st_reg.fcnt;
            endcase
         end
      end

      // x^4+x^3+1 free-running source
      st_next.lfsr = {st_reg.lfsr[2:0], st_reg.lfsr[3] ^ st_reg.lfsr[2]};

      // tag walk, halts at first unknown or masked kind
      nv  = 2'd0;
      run = 1'b1;
      for (int k = 0; k < 3; k++) begin
         kd[k] = tpid_kind(etype_i[k], st_reg.cst);
         if (run && (2'(k) < tag_cnt_i) && (kd[k] != VTLC_EXT_NONE)
             && !st_reg.inv[kd[k] - 3'd1]) begin
            nv = nv + 2'd1;
         end else begin
            run = 1'b0;
         end
      end
      sel = (nv >= 2'd2 && st_reg.ctl[`VTLC_CTL_INNER]) ? 2'd1 : 2'd0;
      pd  = st_reg.xlat[{tci_i[sel][12], tci_i[sel][15:13]}];
      cfg_pop = st_reg.ctl[`VTLC_CTL_POP_LSB +: 2];

      // lag code contributions
      acc = 4'h0;
      if (st_reg.lag_cfg[`VTLC_LAG_DMAC]) begin
         acc = acc ^ fold({80'h0, dmac_i});
      end
      if (st_reg.lag_cfg[`VTLC_LAG_DMACR]) begin
         acc = acc ^ fold({80'h0, mirror48(dmac_i)});
      end
      if (st_reg.lag_cfg[`VTLC_LAG_SMAC]) begin
         acc = acc ^ fold({80'h0, smac_i});
      end
      if (st_reg.lag_cfg[`VTLC_LAG_FLOW] && is_ip6_i) begin
         acc = acc ^ fold({108'h0, flow_lbl_i});
      end
      if (st_reg.lag_cfg[`VTLC_LAG_IP] && is_ip_i) begin
         acc = acc ^ fold(sip_i) ^ fold(dip_i);
      end
      if (st_reg.lag_cfg[`VTLC_LAG_L4] && is_l4_i) begin
         acc = acc ^ fold({96'h0, sport_i, dport_i});
      end
      if (st_reg.lag_cfg[`VTLC_LAG_RAND]) begin
         acc = acc ^ st_reg.lfsr;
      end
      if (st_reg.lag_cfg[`VTLC_LAG_STK] && stk_vld_i) begin
         acc = stk_code_i;
      end

      // one result per frame header strobe
      st_next.rvld = frm_vld_i;
      if (frm_vld_i) begin
         st_next.fcnt = st_reg.fcnt + 16'd1;
         if (nv != 2'd0) begin
            st_next.pcp   = pd[2:0];
            st_next.dei   = pd[3];
            st_next.vid   = tci_i[sel][11:0];
            st_next.ext   = kd[sel];
            st_next.ttype = (kd[sel] != VTLC_EXT_C);
         end else begin
            st_next.pcp   = st_reg.ctl[`VTLC_CTL_PCP_LSB +: 3];
            st_next.dei   = st_reg.ctl[`VTLC_CTL_DEI];
            st_next.vid   = st_reg.ctl[`VTLC_CTL_VID_LSB +: 12];
            st_next.ext   = VTLC_EXT_NONE;
            st_next.ttype = 1'b0;
         end
         st_next.pop  = (cfg_pop > nv) ? nv : cfg_pop;
         st_next.wtag = st_reg.ctl[`VTLC_CTL_AWARE] && (nv != 2'd0);
         st_next.lag  = acc;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= ST_RST;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign prdata_o                   = st_reg.rdata;
   assign pready_o                   = st_reg.rdy;
   assign pslverr_o                  = st_reg.err;
   assign res_vld_o                  = st_reg.rvld;
   assign classified_priority_o      = st_reg.pcp;
   assign classified_drop_eligible_o = st_reg.dei;
   assign classified_vlan_id_o       = st_reg.vid;
   assign tag_type_o                 = st_reg.ttype;
   assign extended_tpid_info_o       = st_reg.ext;
   assign egress_tag_strip_count_o   = st_reg.pop;
   assign was_tagged_o               = st_reg.wtag;
   assign lag_code_o                 = st_reg.lag;
   assign bridge_proto_cpu_enables_o = st_reg.bpdu;
   assign garp_cpu_enables_o         = st_reg.garp;
   assign cfm_cpu_enables_o          = st_reg.cfm;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_frm;
      ce_i && frm_vld_i;
   endsequence
   sequence s_wait;
      ce_i && acc_ph && !pready_o;
   endsequence
   sequence s_wdone;
      ce_i && acc_ph && pready_o && pwrite_i;
   endsequence

   property p_one_result;
      s_frm |=> res_vld_o;
   endproperty
   a_one_result: assert property (p_one_result)
      else $error("no result after frame strobe");

   property p_no_spurious;
      ce_i && !frm_vld_i |=> !res_vld_o;
   endproperty
   a_no_spurious: assert property (p_no_spurious)
      else $error("result without frame strobe");

   property p_untagged;
      s_frm and (tag_cnt_i == 2'd0) |=> !was_tagged_o
         && egress_tag_strip_count_o == 2'd0
         && classified_vlan_id_o == $past(st_reg.ctl[11:0]);
   endproperty
   a_untagged: assert property (p_untagged)
      else $error("untagged frame not given port defaults");

   property p_ctag;
      s_frm and (tag_cnt_i == 2'd1) and (etype_i[0] == `VTLC_TPID_C)
         and !st_reg.inv[0] |=> extended_tpid_info_o == VTLC_EXT_C
         && !tag_type_o && classified_vlan_id_o == $past(tci_i[0][11:0]);
   endproperty
   a_ctag: assert property (p_ctag)
      else $error("customer tag not classified");

   property p_stag;
      s_frm and (tag_cnt_i != 2'd0) and (etype_i[0] == `VTLC_TPID_S)
         and !st_reg.inv[1] and !st_reg.ctl[`VTLC_CTL_INNER]
         |=> extended_tpid_info_o == VTLC_EXT_S && tag_type_o;
   endproperty
   a_stag: assert property (p_stag)
      else $error("service tag not classified");

   property p_stop;
      s_frm and (etype_i[0] == `VTLC_TPID_C) and st_reg.inv[0]
         |=> !was_tagged_o && egress_tag_strip_count_o == 2'd0;
   endproperty
   a_stop: assert property (p_stop)
      else $error("masked outer tag still counted");

   property p_aware;
      res_vld_o && was_tagged_o |-> $past(st_reg.ctl[`VTLC_CTL_AWARE]);
   endproperty
   a_aware: assert property (p_aware)
      else $error("was-tagged set on unaware port");

   property p_clamp;
      res_vld_o |-> egress_tag_strip_count_o <= $past(cfg_pop);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("strip count above configured value");

   property p_stack;
      s_frm and st_reg.lag_cfg[`VTLC_LAG_STK] and stk_vld_i
         |=> lag_code_o == $past(stk_code_i);
   endproperty
   a_stack: assert property (p_stack)
      else $error("stack header code not used");

   property p_apb;
      s_wait |=> pready_o ##1 (!ce_i || !pready_o);
   endproperty
   a_apb: assert property (p_apb)
      else $error("apb ready not a single cycle after one wait");

   property p_err;
      s_wait and (paddr_i[1:0] != 2'h0) |=> pslverr_o;
   endproperty
   a_err: assert property (p_err)
      else $error("misaligned access not refused");

   property p_cpu_en;
      s_wdone and (paddr_i == `VTLC_OFS_BPDU)
         |=> bridge_proto_cpu_enables_o == $past(pwdata_i[15:0]);
   endproperty
   a_cpu_en: assert property (p_cpu_en)
      else $error("bridge protocol enables not written");

   property p_ext_type;
      res_vld_o |-> tag_type_o
         == !(extended_tpid_info_o inside {VTLC_EXT_NONE, VTLC_EXT_C});
   endproperty
   a_ext_type: assert property (p_ext_type)
      else $error("tag type disagrees with extended tpid info");

   property p_pop_idle;
      res_vld_o && !was_tagged_o && $past(st_reg.ctl[`VTLC_CTL_AWARE])
         |-> egress_tag_strip_count_o == 2'd0;
   endproperty
   a_pop_idle: assert property (p_pop_idle)
      else $error("strip count on a frame with no valid tag");

   property p_fcnt;
      s_frm |=> st_reg.fcnt == $past(st_reg.fcnt) + 16'd1;
   endproperty
   a_fcnt: assert property (p_fcnt)
      else $error("frame count not advanced by one");

   property p_hold;
      !frm_vld_i |=> $stable({lag_code_o, was_tagged_o, egress_tag_strip_count_o,
         classified_vlan_id_o, classified_priority_o, extended_tpid_info_o});
   endproperty
   a_hold: assert property (p_hold)
      else $error("results changed without a frame");

   property p_freeze;
      !ce_i |=> $stable(st_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ===== vtlc_params.svh
// constants for the vlan tag classifier and lag code block
`ifndef VTLC_PARAMS_SVH
`define VTLC_PARAMS_SVH
`define VTLC_OFS_CTL      8'h00
`define VTLC_OFS_INV      8'h04
`define VTLC_OFS_CST0     8'h08
`define VTLC_OFS_CST1     8'h0C
`define VTLC_OFS_CST2     8'h10
`define VTLC_OFS_LAG      8'h14
`define VTLC_OFS_BPDU     8'h18
`define VTLC_OFS_GARP     8'h1C
`define VTLC_OFS_CFM      8'h20
`define VTLC_OFS_STAT     8'h24
`define VTLC_XLAT_SEL     2'h1
`define VTLC_CTL_VID_LSB  0
`define VTLC_CTL_PCP_LSB  12
`define VTLC_CTL_DEI      15
`define VTLC_CTL_INNER    16
`define VTLC_CTL_POP_LSB  17
`define VTLC_CTL_AWARE    19
`define VTLC_LAG_DMAC     0
`define VTLC_LAG_DMACR    1
`define VTLC_LAG_SMAC     2
`define VTLC_LAG_FLOW     3
`define VTLC_LAG_IP       4
`define VTLC_LAG_L4       5
`define VTLC_LAG_RAND     6
`define VTLC_LAG_STK      7
`define VTLC_TPID_C       16'h8100
`define VTLC_TPID_S       16'h88A8
`define VTLC_RST_CTL      20'h00000
`define VTLC_RST_CST      16'hFFFF
`define VTLC_RST_LFSR     4'h1
`endif

// ===== vtlc_parser_model.sv
// far-side frame parser model presenting header fields
`timescale 1ns/10ps
`default_nettype none
module vtlc_parser_model (
   input  wire logic         mclk_i,    // core clock
   input  wire logic         rst_n_i,   // async reset
   input  wire logic         go_i,      // present one frame
   input  wire logic [509:0] frame_i,   // packed header fields
   output logic              frm_vld_o, // header strobe
   output logic      [509:0] frame_o    // fields to classifier
);
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frm_vld_o <= 1'b0;
         frame_o   <= '0;
      end else if (go_i) begin
         frm_vld_o <= 1'b1;
         frame_o   <= frame_i;
      end else begin
         // fields stale after the strobe: scramble, never hold
         frm_vld_o <= 1'b0;
         frame_o   <= ~frame_o;
      end
   end
endmodule
`default_nettype wire

// ===== vtlc_pkg.sv
// types of the vlan tag classifier and lag code block
package vtlc_pkg;
   typedef enum logic [2:0] {
      VTLC_EXT_NONE = 3'b000,
      VTLC_EXT_C    = 3'b001,
      VTLC_EXT_S    = 3'b010,
      VTLC_EXT_X0   = 3'b011,
      VTLC_EXT_X1   = 3'b100,
      VTLC_EXT_X2   = 3'b101
   } vtlc_ext_t;

   typedef struct packed {
      logic [19:0]       ctl;
      logic [4:0]        inv;
      logic [2:0][15:0]  cst;
      logic [7:0]        lag_cfg;
      logic [15:0]       bpdu;
      logic [15:0]       garp;
      logic [15:0]       cfm;
      logic [15:0][3:0]  xlat;
      logic [3:0]        lfsr;
      logic [15:0]       fcnt;
      logic              rdy;
      logic              err;
      logic [31:0]       rdata;
      logic              rvld;
      logic [2:0]        pcp;
      logic              dei;
      logic [11:0]       vid;
      logic              ttype;
      vtlc_ext_t         ext;
      logic [1:0]        pop;
      logic              wtag;
      logic [3:0]        lag;
   } vtlc_state_t;
endpackage
